/* File: core/cilc_pkg.sv */
// Constants and types for the converter init and loop-back control registers
package cilc_pkg;
    localparam logic [7:0] ADDR_PHY_ADDRESS = 8'h40;
    localparam logic [7:0] ADDR_PORT_INIT = 8'h43;
    localparam logic [7:0] ADDR_LOOP_SETUP = 8'h44;
    localparam logic [7:0] LOOP_COUNT_RESET = 8'h07;
    localparam logic [7:0] LOOP_COUNT_MAX = 8'h64;
    localparam int BIT_SPEED = 7;
    localparam int BIT_DUPLEX = 6;
    localparam int BIT_AUTONEG = 5;
    localparam int BIT_SOFT_RST = 4;
    localparam int BIT_REMOTE_EN = 3;
    localparam int BIT_LINK_PROP = 2;
    localparam int BIT_TX_TRI = 1;
    localparam int BIT_PHY_RST = 0;

    // One register access from the management controller
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cilc_req_t;

    // Strap pins sampled while reset is held
    typedef struct packed {
        logic center_mode;
        logic speed_strap_pin;
        logic duplex_strap_pin;
        logic autoneg_strap_pin;
        logic link_loss_strap;
    } cilc_strap_t;

    typedef enum logic [1:0] {
        LB_IDLE = 2'b00,
        LB_SEND = 2'b01,
        LB_WAIT = 2'b10
    } cilc_lb_state_t;
endpackage

/* File: core/cilc_loop_seq.sv */
// Center-side loop-back packet sequencer: issues N send requests
`timescale 1ns/1ps
module cilc_loop_seq (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [7:0] i_count,
    input wire logic i_pkt_done,
    output logic o_pkt_send,
    output logic o_busy
);
    import cilc_pkg::*;

    cilc_lb_state_t state_ff, nxt_state;
    logic [7:0] left_ff, nxt_left;

    // Count down one packet per handshake with the frame generator
    always_comb begin
        nxt_state = state_ff;
        nxt_left = left_ff;
        case (state_ff)
            LB_IDLE: begin
                if (i_start && i_count != 8'h00 && i_count <= LOOP_COUNT_MAX) begin
                    nxt_left = i_count;
                    nxt_state = LB_SEND;
                end
            end
            LB_SEND: begin
                nxt_left = left_ff - 8'h01;
                nxt_state = LB_WAIT;
            end
            LB_WAIT: begin
                if (i_pkt_done) begin
                    nxt_state = (left_ff == 8'h00) ? LB_IDLE : LB_SEND;
                end
            end
            default: nxt_state = LB_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= LB_IDLE;
            left_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            left_ff <= nxt_left;
        end
    end

    assign o_pkt_send = (state_ff == LB_SEND);
    assign o_busy = (state_ff != LB_IDLE);

    // Each send consumes one from the remaining count
    send_count_a: assert property (@(posedge i_clock) disable iff (i_rst)
        state_ff == LB_SEND |=> left_ff == $past(left_ff) - 8'h01)
        else $error("loop count not decremented on send");
endmodule

/* File: core/cilc_ctrl.sv */
// Port initialise and loop-back setup registers with their control outputs
`timescale 1ns/1ps
module cilc_ctrl (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire cilc_pkg::cilc_req_t i_req,
    input wire cilc_pkg::cilc_strap_t i_strap,
    input wire logic i_fiber_link_down,
    input wire logic i_center_copper_link_down,
    input wire logic i_pkt_done,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_copper_port_speed_sel,
    output logic o_copper_port_duplex_sel,
    output logic o_copper_port_autoneg_en,
    output logic o_fabric_soft_reset,
    output logic o_phy_reset,
    output logic o_remote_cmd_en,
    output logic o_copper_tx_disable,
    output logic o_copper_led_off,
    output logic o_fiber_tx_oe,
    output logic o_clear_valid_counters,
    output logic o_clear_result_counters,
    output logic o_pkt_send,
    output logic o_loop_busy
);
    import cilc_pkg::*;

    logic speed_ff, nxt_speed;
    logic duplex_ff, nxt_duplex;
    logic autoneg_ff, nxt_autoneg;
    logic remote_ff, nxt_remote;
    logic prop_ff, nxt_prop;
    logic tri_ff, nxt_tri;
    logic phy_hold_ff, nxt_phy_hold;
    logic soft_pulse_ff, nxt_soft_pulse;
    logic phy_pulse_ff, nxt_phy_pulse;
    logic phy_out_ff, nxt_phy_out;
    logic oe_ff, nxt_oe;
    logic [7:0] loop_count_field_ff, nxt_loop_count_field;
    logic clr_valid_ff, nxt_clr_valid;
    logic clr_result_ff, nxt_clr_result;
    logic start_ff, nxt_start;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic tx_dis_ff, nxt_tx_dis;
    logic led_off_ff, nxt_led_off;
    logic pkt_send_ff, busy_ff;
    logic seq_send, seq_busy;
    logic wr_init, wr_loop, wr_phyaddr;

    // Decode a write to one of the handled addresses
    function automatic logic hit(input cilc_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    assign wr_init = hit(i_req, ADDR_PORT_INIT);
    assign wr_loop = hit(i_req, ADDR_LOOP_SETUP);
    assign wr_phyaddr = hit(i_req, ADDR_PHY_ADDRESS);

    // Next values of the initialise register fields
    always_comb begin
        nxt_speed = speed_ff;
        nxt_duplex = duplex_ff;
        nxt_autoneg = autoneg_ff;
        nxt_remote = remote_ff;
        nxt_prop = prop_ff;
        nxt_tri = tri_ff;
        nxt_phy_hold = phy_hold_ff;
        nxt_soft_pulse = 1'b0;
        nxt_phy_pulse = 1'b0;
        if (wr_init) begin
            nxt_speed = i_req.wdata[BIT_SPEED];
            nxt_duplex = i_req.wdata[BIT_DUPLEX];
            nxt_autoneg = i_req.wdata[BIT_AUTONEG];
            nxt_remote = i_req.wdata[BIT_REMOTE_EN];
            nxt_prop = i_req.wdata[BIT_LINK_PROP];
            nxt_tri = i_req.wdata[BIT_TX_TRI];
            nxt_soft_pulse = i_req.wdata[BIT_SOFT_RST];
            nxt_phy_pulse = i_req.wdata[BIT_PHY_RST];
        end
        // Programming the PHY address releases the center-side power-up PHY reset
        if (wr_phyaddr) begin
            nxt_phy_hold = 1'b0;
        end
        // Registered copies so these outputs come straight from flip-flops
        nxt_phy_out = nxt_phy_pulse || nxt_phy_hold;
        nxt_oe = !nxt_tri;
    end

    // Initialise register storage; strap values load while reset is held
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            speed_ff <= i_strap.speed_strap_pin;
            duplex_ff <= i_strap.duplex_strap_pin;
            autoneg_ff <= i_strap.autoneg_strap_pin;
            prop_ff <= i_strap.link_loss_strap;
            phy_hold_ff <= i_strap.center_mode;
            remote_ff <= 1'b0;
            tri_ff <= 1'b0;
            soft_pulse_ff <= 1'b0;
            phy_pulse_ff <= 1'b0;
            phy_out_ff <= i_strap.center_mode;
            oe_ff <= 1'b1;
        end else begin
            speed_ff <= nxt_speed;
            duplex_ff <= nxt_duplex;
            autoneg_ff <= nxt_autoneg;
            prop_ff <= nxt_prop;
            phy_hold_ff <= nxt_phy_hold;
            remote_ff <= nxt_remote;
            tri_ff <= nxt_tri;
            soft_pulse_ff <= nxt_soft_pulse;
            phy_pulse_ff <= nxt_phy_pulse;
            phy_out_ff <= nxt_phy_out;
            oe_ff <= nxt_oe;
        end
    end

    // Loop-back setup register and its clear and start strobes
    always_comb begin
        nxt_loop_count_field = loop_count_field_ff;
        nxt_clr_valid = 1'b0;
        nxt_clr_result = 1'b0;
        nxt_start = 1'b0;
        if (wr_loop) begin
            nxt_loop_count_field = i_req.wdata;
            if (i_req.wdata == 8'h00) begin
                nxt_clr_valid = 1'b1;
                nxt_clr_result = i_strap.center_mode;
            end else begin
                nxt_start = i_strap.center_mode;
            end
        end
    end

    // Loop-back register storage; untouched by the PHY reset pulse
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            loop_count_field_ff <= LOOP_COUNT_RESET;
            clr_valid_ff <= 1'b0;
            clr_result_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            loop_count_field_ff <= nxt_loop_count_field;
            clr_valid_ff <= nxt_clr_valid;
            clr_result_ff <= nxt_clr_result;
            start_ff <= nxt_start;
        end
    end

    cilc_loop_seq u_seq (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_start(start_ff),
        .i_count(loop_count_field_ff),
        .i_pkt_done(i_pkt_done),
        .o_pkt_send(seq_send),
        .o_busy(seq_busy)
    );

    // Read mux; self-clearing soft reset bit reads 0, PHY reset bit reads the held PHY reset
    always_comb begin
        nxt_rdata = 8'h00;
        nxt_rvalid = i_req.rd;
        if (i_req.rd && i_req.addr == ADDR_PORT_INIT) begin
            nxt_rdata = {speed_ff, duplex_ff, autoneg_ff, 1'b0,
                         remote_ff, prop_ff, tri_ff, phy_hold_ff};
        end else if (i_req.rd && i_req.addr == ADDR_LOOP_SETUP) begin
            nxt_rdata = loop_count_field_ff;
        end
    end

    // Link-loss propagation applies only to the terminal side
    always_comb begin
        nxt_tx_dis = !i_strap.center_mode && prop_ff &&
                     (i_fiber_link_down || i_center_copper_link_down);
        nxt_led_off = nxt_tx_dis;
    end

    // Output registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
            tx_dis_ff <= 1'b0;
            led_off_ff <= 1'b0;
            pkt_send_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            tx_dis_ff <= nxt_tx_dis;
            led_off_ff <= nxt_led_off;
            pkt_send_ff <= seq_send;
            busy_ff <= seq_busy;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_rvalid = rvalid_ff;
    assign o_copper_port_speed_sel = speed_ff;
    assign o_copper_port_duplex_sel = duplex_ff;
    assign o_copper_port_autoneg_en = autoneg_ff;
    assign o_fabric_soft_reset = soft_pulse_ff;
    assign o_phy_reset = phy_out_ff;
    assign o_remote_cmd_en = remote_ff;
    assign o_copper_tx_disable = tx_dis_ff;
    assign o_copper_led_off = led_off_ff;
    assign o_fiber_tx_oe = oe_ff;
    assign o_clear_valid_counters = clr_valid_ff;
    assign o_clear_result_counters = clr_result_ff;
    assign o_pkt_send = pkt_send_ff;
    assign o_loop_busy = busy_ff;

    // Soft reset is one cycle wide after a write of 1, unless written again
    soft_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init && i_req.wdata[BIT_SOFT_RST] |=> o_fabric_soft_reset ##1
        (!o_fabric_soft_reset || $past(wr_init && i_req.wdata[BIT_SOFT_RST])))
        else $error("soft reset pulse not single");
    // No soft reset without a write of 1
    soft_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !(wr_init && i_req.wdata[BIT_SOFT_RST]) |=> !o_fabric_soft_reset)
        else $error("soft reset without write");
    // PHY reset pulse follows a write of 1
    phy_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init && i_req.wdata[BIT_PHY_RST] |=> o_phy_reset)
        else $error("phy reset missing");
    // Programming the PHY address drops the held PHY reset
    phy_release_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_phyaddr |=> !o_phy_reset)
        else $error("phy reset not released");
    // Copper speed takes the written value
    speed_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init |=> o_copper_port_speed_sel == $past(i_req.wdata[BIT_SPEED]))
        else $error("speed field not written");
    // Copper duplex takes the written value
    duplex_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init |=> o_copper_port_duplex_sel == $past(i_req.wdata[BIT_DUPLEX]))
        else $error("duplex field not written");
    // Copper auto-negotiation takes the written value
    autoneg_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init |=> o_copper_port_autoneg_en == $past(i_req.wdata[BIT_AUTONEG]))
        else $error("autoneg field not written");
    // Remote enable takes the written value
    remote_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init |=> o_remote_cmd_en == $past(i_req.wdata[BIT_REMOTE_EN]))
        else $error("remote enable not written");
    // Center side never propagates link loss
    center_ignore_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_strap.center_mode |=> !o_copper_tx_disable && !o_copper_led_off)
        else $error("center side propagated link loss");
    // Terminal side with propagation enabled reacts to fiber link loss
    link_prop_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_strap.center_mode && prop_ff && i_fiber_link_down |=> o_copper_led_off)
        else $error("link loss not propagated");
    // Terminal side with propagation enabled reacts to copper link loss
    copper_prop_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_strap.center_mode && prop_ff && i_center_copper_link_down |=> o_copper_tx_disable)
        else $error("copper link loss not propagated");
    // With both links up the copper side stays enabled
    link_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_fiber_link_down && !i_center_copper_link_down |=>
        !o_copper_tx_disable && !o_copper_led_off)
        else $error("copper disabled with links up");
    // Zero write clears valid counters next cycle
    zero_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_loop && i_req.wdata == 8'h00 |=> o_clear_valid_counters)
        else $error("zero write did not clear");
    // Zero write clears result counters on the center side only
    result_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_loop && i_req.wdata == 8'h00 |=>
        o_clear_result_counters == $past(i_strap.center_mode))
        else $error("result counter clear wrong");
    // Counter clears only follow a loop-back write
    clear_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !wr_loop |=> !o_clear_valid_counters && !o_clear_result_counters)
        else $error("counter clear without write");
    // A legal count on an idle center side sends its first packet
    loop_start_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_loop && i_strap.center_mode && !seq_busy && !start_ff && i_req.wdata != 8'h00 &&
        i_req.wdata <= LOOP_COUNT_MAX |=> ##2 o_pkt_send)
        else $error("loop-back run did not start");
    // Loop count survives everything but its own write
    loop_keep_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !wr_loop |=> loop_count_field_ff == $past(loop_count_field_ff))
        else $error("loop count changed without write");
    // Fiber output enable follows the tri-state bit
    fiber_tri_a: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_init |=> o_fiber_tx_oe == !$past(i_req.wdata[BIT_TX_TRI]))
        else $error("fiber tri-state wrong");
    // Remote enable holds between writes
    remote_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !wr_init |=> o_remote_cmd_en == $past(o_remote_cmd_en))
        else $error("remote enable changed without write");
    // Read of the init register shows the self-clearing soft bit as 0
    read_zero_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_req.rd && i_req.addr == ADDR_PORT_INIT |=> o_rvalid && !o_rdata[BIT_SOFT_RST])
        else $error("soft reset bit read as 1");
    // Without the held reset the PHY reset bit reads 0
    read_phy_zero_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_req.rd && i_req.addr == ADDR_PORT_INIT && !phy_hold_ff |=> !o_rdata[BIT_PHY_RST])
        else $error("phy reset bit read as 1");
    // Loop setup read returns the stored count
    read_loop_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_req.rd && i_req.addr == ADDR_LOOP_SETUP |=> o_rvalid &&
        o_rdata == $past(loop_count_field_ff))
        else $error("loop count read wrong");
endmodule

/* File: bench/cilc_mgmt_model.sv */
// Management controller model that issues register accesses
`timescale 1ns/1ps
module cilc_mgmt_model #(
    parameter logic [7:0] PHY1_ADDR = 8'h03
) (
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output cilc_pkg::cilc_req_t o_req
);
    import cilc_pkg::*;

    initial o_req = '0;

    // Hold the request one edge, then idle with inverted address and data
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge i_clock);
        #1;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        if (a == ADDR_LOOP_SETUP && d > LOOP_COUNT_MAX) begin
            d = LOOP_COUNT_MAX;
        end
        access(1'b1, a, d);
    endtask

    // Read data is taken at the edge after the request
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        access(1'b0, a, 8'h00);
        d = i_rdata;
        v = i_rvalid;
    endtask

    // Program the fiber PHY address to start center-side operation
    task automatic start_center();
        write(ADDR_PHY_ADDRESS, PHY1_ADDR);
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the init and loop-back control registers
`timescale 1ns/1ps
module testbench;
    import cilc_pkg::*;

    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    cilc_req_t i_req;
    cilc_strap_t i_strap = '0;
    logic i_fiber_link_down = 1'b0;
    logic i_center_copper_link_down = 1'b0;
    logic i_pkt_done = 1'b0;
    logic [7:0] o_rdata;
    logic o_rvalid, o_speed, o_duplex, o_autoneg, o_soft, o_phy, o_remote;
    logic o_tx_dis, o_led_off, o_fiber_oe, o_clr_valid, o_clr_result, o_pkt_send, o_busy;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 i_clock = ~i_clock;

    cilc_mgmt_model mgmt (.i_clock(i_clock), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_req(i_req));

    cilc_ctrl DUT (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .i_strap(i_strap),
        .i_fiber_link_down(i_fiber_link_down),
        .i_center_copper_link_down(i_center_copper_link_down), .i_pkt_done(i_pkt_done),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_copper_port_speed_sel(o_speed),
        .o_copper_port_duplex_sel(o_duplex), .o_copper_port_autoneg_en(o_autoneg),
        .o_fabric_soft_reset(o_soft), .o_phy_reset(o_phy), .o_remote_cmd_en(o_remote),
        .o_copper_tx_disable(o_tx_dis), .o_copper_led_off(o_led_off),
        .o_fiber_tx_oe(o_fiber_oe), .o_clear_valid_counters(o_clr_valid),
        .o_clear_result_counters(o_clr_result), .o_pkt_send(o_pkt_send),
        .o_loop_busy(o_busy));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read a register and compare valid flag and data
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        mgmt.read(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask

    // Run a loop-back count while answering each packet after a random delay
    task automatic run_loop(input logic [7:0] n, input logic cm);
        int sent;
        int dly;
        logic pend;
        logic saw_busy;
        sent = 0;
        pend = 1'b0;
        saw_busy = 1'b0;
        dly = 0;
        mgmt.write(ADDR_LOOP_SETUP, n);
        for (int c = 0; c < 1000; c++) begin
            @(posedge i_clock);
            #1;
            i_pkt_done = pend && dly == 0;
            if (pend && dly == 0) pend = 1'b0;
            else if (pend) dly--;
            if (o_busy === 1'b1) saw_busy = 1'b1;
            if (o_pkt_send === 1'b1) begin
                sent++;
                pend = 1'b1;
                dly = $urandom_range(0, 3);
            end
            if (c > 4 && o_busy !== 1'b1 && !pend) break;
        end
        check(8'(sent), cm ? n : 8'h00);
        check({7'h00, saw_busy}, {7'h00, cm});
        check({7'h00, o_busy}, 8'h00);
        rd_chk(ADDR_LOOP_SETUP, n);
    endtask

    // Cut a hang short
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        logic [7:0] init_exp;
        logic [7:0] v;
        logic sel;
        void'($urandom(7506));
        for (int m = 0; m < 2; m++) begin
            i_rst = 1'b1;
            i_strap = {m[0], 4'($urandom)};
            repeat (5) @(posedge i_clock);
            #1;
            i_rst = 1'b0;
            init_exp = {i_strap[3:1], 2'b00, i_strap[0], 1'b0, m[0]};
            check({5'h00, o_speed, o_duplex, o_autoneg}, {5'h00, init_exp[7:5]});
            check({7'h00, o_remote}, 8'h00);
            check({6'h00, o_fiber_oe, o_phy}, {6'h00, 1'b1, m[0]});
            rd_chk(ADDR_PORT_INIT, init_exp);
            rd_chk(ADDR_LOOP_SETUP, LOOP_COUNT_RESET);
            rd_chk(8'h50, 8'h00);
            // Self-clearing bits pulse once and read back zero, except that the PHY reset stays at and reads back the held reset
            v = 8'($urandom) | 8'h11;
            mgmt.write(ADDR_PORT_INIT, v);
            check({6'h00, o_soft, o_phy}, 8'h03);
            @(posedge i_clock);
            #1;
            check({6'h00, o_soft, o_phy}, {7'h00, m[0]});
            rd_chk(ADDR_PORT_INIT, (v & 8'hee) | {7'h00, m[0]});
            check({5'h00, o_speed, o_duplex, o_autoneg}, {5'h00, v[7:5]});
            check({7'h00, o_remote}, {7'h00, v[3]});
            check({7'h00, o_fiber_oe}, {7'h00, ~v[1]});
            // Link loss propagation, terminal mode only
            mgmt.write(ADDR_PORT_INIT, 8'h04);
            sel = 1'($urandom);
            i_fiber_link_down = sel;
            i_center_copper_link_down = ~sel;
            @(posedge i_clock);
            #1;
            check({6'h00, o_tx_dis, o_led_off}, {6'h00, ~m[0], ~m[0]});
            i_fiber_link_down = 1'b0;
            i_center_copper_link_down = 1'b0;
            @(posedge i_clock);
            #1;
            check({6'h00, o_tx_dis, o_led_off}, 8'h00);
            mgmt.start_center();
            check({7'h00, o_phy}, 8'h00);
            // Zero write clears counters
            mgmt.write(ADDR_LOOP_SETUP, 8'h00);
            check({6'h00, o_clr_valid, o_clr_result}, {6'h00, 1'b1, m[0]});
            run_loop(8'h01, m[0]);
            run_loop(LOOP_COUNT_MAX, m[0]);
            v = 8'($urandom_range(2, 99));
            run_loop(v, m[0]);
            mgmt.write(ADDR_PORT_INIT, 8'h01);
            rd_chk(ADDR_LOOP_SETUP, v);
        end
        stop_test();
    end
endmodule
